// ### include/mbst_defines.vh
// constants for the memory boundary-scan test port
// Function
// RULE1: instruction 3 bits, bypass 1, identification 32, boundary chain 109 cells.
// RULE2: code 001 loads identification word, selects it, memory unaffected.
// RULE3: code 010 captures pins, selects boundary chain, floats all memory outputs.
// RULE4: code 100 samples pin ring into chain, selects chain, memory unaffected.
// RULE5: code 111 puts one-bit bypass between data in and data out.
// RULE6: controller never loads reserved codes 011, 101 or 110; update-IR loads them like any code, and they decode as bypass.
// RULE7: remaining code 000 is external test, capturing the pin ring.
// RULE8: identification bit 0 always reads one.
// RULE9: revision in bits 31:29, part type in 28:12, both hardwired.
// RULE10: bits 11:1 hold a hardwired vendor code.
// RULE11: mode and data sampled on test clock rise; data out updates after fall.
// RULE12: cell 108 is output-enable control under external test; high drives.
// RULE13: output-enable cell presets high at power-up and test-logic reset.
// RULE14: identification instruction becomes current at power-up and test-logic reset.
// RULE15: standard sixteen-state controller; instruction takes effect at update-IR.
// RULE16: selected register shifts toward data out, lsb first, one bit per clock.
`ifndef MBST_DEFINES_VH
`define MBST_DEFINES_VH
`define MBST_IR_LEN 3
`define MBST_ID_LEN 32
`define MBST_BSR_LEN 109
`define MBST_OE_CELL 108
`define MBST_PIN_CELLS 108
`define MBST_OP_EXTEST 3'h0
`define MBST_OP_IDCODE 3'h1
`define MBST_OP_SAMPZ 3'h2
`define MBST_OP_SAMPLE 3'h4
`define MBST_OP_BYPASS 3'h7
`define MBST_IR_CAPTURE 3'h1
// arbitrary neutral identity values
`define MBST_ID_REV 3'h5
`define MBST_ID_PART 17'h0a5a5
`define MBST_ID_VENDOR 11'h2aa
// fsm state codes
`define MBST_S_RESET 4'h0
`define MBST_S_IDLE 4'h1
`define MBST_S_SEL_DR 4'h2
`define MBST_S_CAP_DR 4'h3
`define MBST_S_SH_DR 4'h4
`define MBST_S_EX1_DR 4'h5
`define MBST_S_PAU_DR 4'h6
`define MBST_S_EX2_DR 4'h7
`define MBST_S_UPD_DR 4'h8
`define MBST_S_SEL_IR 4'h9
`define MBST_S_CAP_IR 4'ha
`define MBST_S_SH_IR 4'hb
`define MBST_S_EX1_IR 4'hc
`define MBST_S_PAU_IR 4'hd
`define MBST_S_EX2_IR 4'he
`define MBST_S_UPD_IR 4'hf
`endif

// ### logic/mbst_sync.v
// two-flop synchroniser for one pin
`timescale 1ns/10ps
module mbst_sync (
  input wire clk,
  input wire rst_b,
  input wire ce,
  input wire d,
  output reg q
);
  reg meta;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta <= 1'b0;
      q <= 1'b0;
    end else if (ce) begin
      meta <= d;
      q <= meta;
    end
  end
endmodule // mbst_sync

// ### logic/mbst_fsm.v
// sixteen-state test controller, advanced once per test clock rise
`timescale 1ns/10ps
`include "mbst_defines.vh"
module mbst_fsm (
  input wire clk,
  input wire rst_b,
  input wire adv,
  input wire tms,
  output reg [3:0] state
);
  reg [3:0] next_state;
  always @* begin
    case (state) // RULE15
      `MBST_S_RESET: next_state = tms ? `MBST_S_RESET : `MBST_S_IDLE;
      `MBST_S_IDLE: next_state = tms ? `MBST_S_SEL_DR : `MBST_S_IDLE;
      `MBST_S_SEL_DR: next_state = tms ? `MBST_S_SEL_IR : `MBST_S_CAP_DR;
      `MBST_S_CAP_DR: next_state = tms ? `MBST_S_EX1_DR : `MBST_S_SH_DR;
      `MBST_S_SH_DR: next_state = tms ? `MBST_S_EX1_DR : `MBST_S_SH_DR;
      `MBST_S_EX1_DR: next_state = tms ? `MBST_S_UPD_DR : `MBST_S_PAU_DR;
      `MBST_S_PAU_DR: next_state = tms ? `MBST_S_EX2_DR : `MBST_S_PAU_DR;
      `MBST_S_EX2_DR: next_state = tms ? `MBST_S_UPD_DR : `MBST_S_SH_DR;
      `MBST_S_UPD_DR: next_state = tms ? `MBST_S_SEL_DR : `MBST_S_IDLE;
      `MBST_S_SEL_IR: next_state = tms ? `MBST_S_RESET : `MBST_S_CAP_IR;
      `MBST_S_CAP_IR: next_state = tms ? `MBST_S_EX1_IR : `MBST_S_SH_IR;
      `MBST_S_SH_IR: next_state = tms ? `MBST_S_EX1_IR : `MBST_S_SH_IR;
      `MBST_S_EX1_IR: next_state = tms ? `MBST_S_UPD_IR : `MBST_S_PAU_IR;
      `MBST_S_PAU_IR: next_state = tms ? `MBST_S_EX2_IR : `MBST_S_PAU_IR;
      `MBST_S_EX2_IR: next_state = tms ? `MBST_S_UPD_IR : `MBST_S_SH_IR;
      `MBST_S_UPD_IR: next_state = tms ? `MBST_S_SEL_DR : `MBST_S_IDLE;
      default: next_state = `MBST_S_RESET;
    endcase
  end
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= `MBST_S_RESET;
    end else if (adv) begin
      state <= next_state;
    end
  end
endmodule // mbst_fsm

// ### logic/mbst_tap.v
// boundary-scan test port of the burst memory, oversampling the test clock
`timescale 1ns/10ps
`include "mbst_defines.vh"
module mbst_tap (
  input wire CLK,
  input wire RST_B,
  input wire CE,
  input wire TCK,
  input wire TMS,
  input wire TDI,
  input wire [107:0] PIN_IN,
  output reg TDO,
  output reg TDO_OE_B,
  output reg MEM_OE_B,
  output reg EXTEST_ACTIVE,
  output reg [107:0] PIN_DRIVE
);
  wire tck_s;
  wire tms_s;
  wire tdi_s;
  reg tck_d;
  wire tck_rise;
  wire tck_fall;
  wire [3:0] state;
  reg [2:0] instr;
  reg [2:0] ir_shift; // RULE1
  reg bypass; // RULE1
  reg [31:0] id_shift; // RULE1
  reg [108:0] bsr_shift; // RULE1
  reg [108:0] bsr_latch;
  reg tdo_next;
  wire [31:0] id_word;
  reg id_sel;
  reg bsr_sel;
  reg byp_sel;
  reg float_sel;
  reg ext_sel;
  reg [2:0] next_instr;
  reg [2:0] next_ir_shift;
  reg next_bypass;
  reg [31:0] next_id_shift;
  reg [108:0] next_bsr_shift;
  reg [108:0] next_bsr_latch;
  reg [107:0] pin_meta;
  reg [107:0] pin_s;
  wire in_reset;
  wire in_shift;
  wire cap_ir;
  wire sh_ir;
  wire upd_ir;
  wire cap_dr;
  wire sh_dr;
  wire upd_dr;

  mbst_sync u_sync_tck (.clk(CLK), .rst_b(RST_B), .ce(CE), .d(TCK), .q(tck_s));
  mbst_sync u_sync_tms (.clk(CLK), .rst_b(RST_B), .ce(CE), .d(TMS), .q(tms_s));
  mbst_sync u_sync_tdi (.clk(CLK), .rst_b(RST_B), .ce(CE), .d(TDI), .q(tdi_s));

  // edge finder works only on the synchronised copy
  assign tck_rise = CE & tck_s & ~tck_d; // RULE11
  assign tck_fall = CE & ~tck_s & tck_d; // RULE11

  mbst_fsm u_fsm (.clk(CLK), .rst_b(RST_B), .adv(tck_rise), .tms(tms_s), .state(state));

  // controller actions as single-clock strobes; in_reset and in_shift are levels
  assign in_reset = (state == `MBST_S_RESET);
  assign in_shift = (state == `MBST_S_SH_IR) | (state == `MBST_S_SH_DR);
  assign cap_ir = tck_rise & (state == `MBST_S_CAP_IR);
  assign sh_ir = tck_rise & (state == `MBST_S_SH_IR);
  assign upd_ir = tck_rise & (state == `MBST_S_UPD_IR);
  assign cap_dr = tck_rise & (state == `MBST_S_CAP_DR);
  assign sh_dr = tck_rise & (state == `MBST_S_SH_DR);
  assign upd_dr = tck_rise & (state == `MBST_S_UPD_DR);

  assign id_word = {`MBST_ID_REV, `MBST_ID_PART, `MBST_ID_VENDOR, 1'b1}; // RULE8 RULE9 RULE10

  // reserved codes decode as bypass; the controller is not meant to load them
  always @* begin
    id_sel = 1'b0;
    bsr_sel = 1'b0;
    byp_sel = 1'b0;
    float_sel = 1'b0;
    ext_sel = 1'b0;
    case (instr)
      `MBST_OP_EXTEST: begin
        bsr_sel = 1'b1; // RULE7
        ext_sel = 1'b1; // RULE12
      end
      `MBST_OP_IDCODE: begin
        id_sel = 1'b1; // RULE2
      end
      `MBST_OP_SAMPZ: begin
        bsr_sel = 1'b1; // RULE3
        float_sel = 1'b1; // RULE3
      end
      `MBST_OP_SAMPLE: begin
        bsr_sel = 1'b1; // RULE4
      end
      `MBST_OP_BYPASS: begin
        byp_sel = 1'b1; // RULE5
      end
      default: begin
        byp_sel = 1'b1; // RULE6
      end
    endcase
  end

  always @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      tck_d <= 1'b0;
    end else if (CE) begin
      tck_d <= tck_s;
    end
  end

  // pin ring runs on the memory clock; two flops keep the capture clean
  always @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      pin_meta <= 108'h0;
      pin_s <= 108'h0;
    end else if (CE) begin
      pin_meta <= PIN_IN;
      pin_s <= pin_meta;
    end
  end

  // identification stays current for as long as the controller rests in reset
  always @* begin
    next_instr = instr;
    if (in_reset) begin
      next_instr = `MBST_OP_IDCODE; // RULE14
    end else if (upd_ir) begin
      next_instr = ir_shift; // RULE15
    end
  end

  always @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      instr <= `MBST_OP_IDCODE;
    end else if (CE) begin
      instr <= next_instr;
    end
  end

  // fixed capture value marks the instruction register in a board chain
  always @* begin
    next_ir_shift = ir_shift;
    if (cap_ir) begin
      next_ir_shift = `MBST_IR_CAPTURE;
    end else if (sh_ir) begin
      next_ir_shift = {tdi_s, ir_shift[2:1]}; // RULE16
    end
  end

  always @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      ir_shift <= `MBST_IR_CAPTURE;
    end else if (CE) begin
      ir_shift <= next_ir_shift;
    end
  end

  always @* begin
    next_bypass = bypass;
    if (cap_dr & byp_sel) begin
      next_bypass = 1'b0; // RULE5
    end else if (sh_dr & byp_sel) begin
      next_bypass = tdi_s; // RULE5
    end
  end

  always @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      bypass <= 1'b0;
    end else if (CE) begin
      bypass <= next_bypass;
    end
  end

  always @* begin
    next_id_shift = id_shift;
    if (cap_dr & id_sel) begin
      next_id_shift = id_word; // RULE2
    end else if (sh_dr & id_sel) begin
      next_id_shift = {tdi_s, id_shift[31:1]}; // RULE16
    end
  end

  always @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      id_shift <= 32'h0;
    end else if (CE) begin
      id_shift <= next_id_shift;
    end
  end

  // control cell recaptures its own latch so a sample never clears it
  always @* begin
    next_bsr_shift = bsr_shift;
    if (cap_dr & bsr_sel) begin
      next_bsr_shift = {bsr_latch[`MBST_OE_CELL], pin_s}; // RULE3 RULE4 RULE7
    end else if (sh_dr & bsr_sel) begin
      next_bsr_shift = {tdi_s, bsr_shift[108:1]}; // RULE16
    end
  end

  always @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      bsr_shift <= 109'h0;
    end else if (CE) begin
      bsr_shift <= next_bsr_shift;
    end
  end

  // only the update strobe and test-logic reset (control cell) move the latch, so pins hold while shifting
  always @* begin
    next_bsr_latch = bsr_latch;
    if (upd_dr & bsr_sel) begin
      next_bsr_latch = bsr_shift; // RULE12
    end else if (in_reset) begin
      next_bsr_latch[`MBST_OE_CELL] = 1'b1; // RULE13
    end
  end

  always @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      bsr_latch <= {1'b1, 108'h0};
    end else if (CE) begin
      bsr_latch <= next_bsr_latch;
    end
  end

  // instruction register first in shift-IR, else the selected data register
  always @* begin
    case (state)
      `MBST_S_SH_IR: begin
        tdo_next = ir_shift[0]; // RULE16
      end
      default: begin
        if (id_sel) begin
          tdo_next = id_shift[0];
        end else if (bsr_sel) begin
          tdo_next = bsr_shift[0];
        end else begin
          tdo_next = bypass;
        end
      end
    endcase
  end

  // serial output moves only after a falling test clock edge
  always @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      TDO <= 1'b0;
    end else if (tck_fall) begin
      TDO <= tdo_next; // RULE11
    end
  end

  // driver enabled only while a register sits between the serial pins
  always @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      TDO_OE_B <= 1'b1;
    end else if (tck_fall) begin
      TDO_OE_B <= ~in_shift; // RULE11
    end
  end

  // pad logic uses the latched values only under external test
  always @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      EXTEST_ACTIVE <= 1'b0;
    end else if (CE) begin
      EXTEST_ACTIVE <= ext_sel; // RULE7
    end
  end

  always @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      PIN_DRIVE <= 108'h0;
    end else if (CE) begin
      PIN_DRIVE <= bsr_latch[107:0]; // RULE12
    end
  end

  // memory outputs follow the instruction one clock later
  always @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      MEM_OE_B <= 1'b0;
    end else if (CE) begin
      if (float_sel) begin
        MEM_OE_B <= 1'b1; // RULE3
      end else if (ext_sel) begin
        MEM_OE_B <= ~bsr_latch[`MBST_OE_CELL]; // RULE12
      end else begin
        MEM_OE_B <= 1'b0; // RULE2 RULE4 RULE5
      end
    end
  end
endmodule // mbst_tap

// ### dv/mbst_tap_monitor.sv
// pin-level assertions for the test port
`timescale 1ns/10ps
module mbst_monitor (
  input wire CLK,
  input wire RST_B,
  input wire TCK,
  input wire TMS,
  input wire TDO,
  input wire TDO_OE_B,
  input wire MEM_OE_B,
  input wire EXTEST_ACTIVE,
  input wire [107:0] PIN_DRIVE
);
  reg tq;
  reg [3:0] cf;
  reg [3:0] cr;
  reg [2:0] n1;
  // ages since test clock edges, saturating so old edges never wrap
  always @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      tq <= 1'b0;
      cf <= 4'hf;
      cr <= 4'hf;
      n1 <= 3'h5;
    end else begin
      tq <= TCK;
      cf <= (tq && !TCK) ? 4'h0 : cf + {3'h0, cf != 4'hf};
      cr <= (!tq && TCK) ? 4'h0 : cr + {3'h0, cr != 4'hf};
      if (!tq && TCK) begin
        n1 <= TMS ? n1 + {2'h0, n1 != 3'h5} : 3'h0;
      end
    end
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_B);
  sequence s_rst_out; !EXTEST_ACTIVE && !MEM_OE_B && TDO_OE_B; endsequence
  property p_tdo; $changed(TDO) |-> cf < 4'h8; endproperty
  a_tdo: assert property (p_tdo) else $error("tdo moved off a fall");
  property p_oe; $changed(TDO_OE_B) |-> cf < 4'h8; endproperty
  a_oe: assert property (p_oe) else $error("tdo enable off a fall");
  property p_tlr; n1 == 3'h5 |-> ##8 s_rst_out; endproperty
  a_tlr: assert property (p_tlr) else $error("no reset state");
  property p_ext; $changed(EXTEST_ACTIVE) |-> cr < 4'h8; endproperty
  a_ext: assert property (p_ext) else $error("instr off a rise");
  property p_mem; $changed(MEM_OE_B) |-> cr < 4'h8; endproperty
  a_mem: assert property (p_mem) else $error("mem enable off a rise");
  property p_drv; $changed(PIN_DRIVE) |-> cr < 4'h8; endproperty
  a_drv: assert property (p_drv) else $error("latch off a rise");
  property p_len; $fell(TDO_OE_B) |-> !TDO_OE_B [*7]; endproperty
  a_len: assert property (p_len) else $error("shift too short");
  property p_upd; $rose(EXTEST_ACTIVE) |-> TDO_OE_B; endproperty
  a_upd: assert property (p_upd) else $error("instr set in shift");
endmodule // mbst_monitor
bind mbst_tap mbst_monitor mon (.CLK(CLK), .RST_B(RST_B), .TCK(TCK), .TMS(TMS), .TDO(TDO),
  .TDO_OE_B(TDO_OE_B), .MEM_OE_B(MEM_OE_B), .EXTEST_ACTIVE(EXTEST_ACTIVE),
  .PIN_DRIVE(PIN_DRIVE));

// ### dv/mbst_ctl.sv
// board test controller model on the serial test pins
`timescale 1ns/10ps
module mbst_ctl (
  input wire clk,
  input wire tdo,
  output logic tck = 1'b0,
  output logic tms = 1'b1,
  output logic tdi = 1'b0
);
  // one test clock of 8 system clocks; tdo read late, port sees edges 3 clocks late
  task step(input logic m, input logic d, output logic o);
    @(posedge clk);
    tms <= m;
    tdi <= d;
    repeat (3) @(posedge clk);
    tck <= 1'b1;
    repeat (4) @(posedge clk);
    o = tdo;
    tck <= 1'b0;
  endtask
endmodule // mbst_ctl

// ### dv/memory_boundary_scan_tap_test.sv
// self-checking bench for the test port
`timescale 1ns/10ps
`include "mbst_defines.vh"
module memory_boundary_scan_tap_test;
  logic CLK = 1'b0;
  logic RST_B = 1'b0;
  logic CE = 1'b1;
  logic [107:0] PIN_IN = '0;
  wire TCK, TMS, TDI, TDO, TDO_OE_B, MEM_OE_B, EXTEST_ACTIVE;
  wire [107:0] PIN_DRIVE;
  int bad_count = 0;
  int samples_checked = 0;
  logic j;
  logic [108:0] o;
  logic [108:0] pat = {1'b0, {27{4'h6}}};
  initial forever #50 CLK = ~CLK;
  mbst_tap dut (.CLK(CLK), .RST_B(RST_B), .CE(CE), .TCK(TCK), .TMS(TMS), .TDI(TDI),
    .PIN_IN(PIN_IN), .TDO(TDO), .TDO_OE_B(TDO_OE_B), .MEM_OE_B(MEM_OE_B),
    .EXTEST_ACTIVE(EXTEST_ACTIVE), .PIN_DRIVE(PIN_DRIVE));
  mbst_ctl ctl (.clk(CLK), .tdo(TDO), .tck(TCK), .tms(TMS), .tdi(TDI));
  task chk(input string n, input logic [108:0] s, input logic [108:0] e);
    @(negedge CLK);
    samples_checked++;
    if (s !== e) begin
      bad_count++;
      $display("MISMATCH %s exp %h got %h", n, e, s);
    end
  endtask
  task sh(input int n, input logic [108:0] d);
    o = '0;
    for (int i = 0; i < n; i++) ctl.step(i == n - 1, d[i], o[i]);
    chk("oe shift", TDO_OE_B, 1'b0);
    ctl.step(1'b1, 1'b1, j);
    ctl.step(1'b0, 1'b1, j);
  endtask
  // only four of the five defined codes are ever loaded; identification comes from reset
  task ir(input logic [2:0] c);
    for (int i = 0; i < 4; i++) ctl.step(i < 2, 1'b1, j);
    sh(3, {106'h0, c});
    chk("ir cap", o[2:0], 3'h1);
  endtask
  task dr(input int n, input logic [108:0] d);
    for (int i = 0; i < 3; i++) ctl.step(i == 0, 1'b1, j);
    sh(n, d);
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge CLK);
    RST_B <= 1'b1;
    PIN_IN <= {27{4'h9}};
    ctl.step(1'b0, 1'b1, j);
    dr(32, '0);
    chk("id", o[31:0], {`MBST_ID_REV, `MBST_ID_PART, `MBST_ID_VENDOR, 1'b1});
    chk("id mem", MEM_OE_B, 1'b0);
    ir(`MBST_OP_BYPASS);
    dr(2, 2'h3);
    chk("bypass", o[1:0], 2'h2);
    $display("id and bypass done");
    ir(`MBST_OP_SAMPLE);
    dr(109, pat);
    chk("sample", o, {1'b1, PIN_IN});
    chk("preload", {MEM_OE_B, PIN_DRIVE}, {1'b0, pat[107:0]});
    ir(`MBST_OP_EXTEST);
    chk("ext off", {EXTEST_ACTIVE, MEM_OE_B}, 2'h3);
    @(posedge CLK);
    CE <= 1'b0;
    ctl.step(1'b1, 1'b1, j);
    @(posedge CLK);
    CE <= 1'b1;
    chk("ce hold", {EXTEST_ACTIVE, MEM_OE_B}, 2'h3);
    ir(`MBST_OP_SAMPZ);
    chk("samp z", {EXTEST_ACTIVE, MEM_OE_B}, 2'h1);
    $display("sample done");
    repeat (5) ctl.step(1'b1, 1'b1, j);
    ctl.step(1'b0, 1'b1, j);
    ir(`MBST_OP_EXTEST);
    chk("ext on", {EXTEST_ACTIVE, MEM_OE_B}, 2'h2);
    dr(109, {1'b0, ~pat[107:0]});
    chk("ext cap", o, {1'b1, PIN_IN});
    chk("ext upd", {MEM_OE_B, PIN_DRIVE}, {1'b1, ~pat[107:0]});
    chk("oe idle", TDO_OE_B, 1'b1);
    $display("reset and extest done");
    report_and_stop();
  end
endmodule // memory_boundary_scan_tap_test
